// >>> hw/drdt_map.vh
// Function
// - Two enable bits, bit1 second, bit0 first
// - Software start value loads counter on init
// - Interrupt period is start plus one ticks
// - Counter read returns live count
// - Counter write replaces live count
// - Each timer has own underflow interrupt
// - Enabled timer decrements once per tick
// - Underflow reloads start value, keeps looping
// - Shared prescaler divides by field plus one
`ifndef DRDT_MAP_VH
`define DRDT_MAP_VH
`define DRDT_OFS_CONFIG    6'h00
`define DRDT_OFS_ENABLE    6'h04
`define DRDT_OFS_T0_START  6'h08
`define DRDT_OFS_T0_COUNT  6'h0C
`define DRDT_OFS_T1_START  6'h10
`define DRDT_OFS_T1_COUNT  6'h14
`define DRDT_OFS_IRQ_STAT  6'h18
`define DRDT_OFS_IRQ_EN    6'h1C
`define DRDT_OFS_IRQ_CLR   6'h20
`define DRDT_DIV_W         8
`define DRDT_DIV_RST       8'h00
`define DRDT_EN_RST        2'h0
`define DRDT_CNT_RST       32'h00000000
`define DRDT_RESP_OKAY     2'h0
`define DRDT_RESP_SLVERR   2'h2
`endif

// >>> hw/drdt_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "drdt_map.vh"
module drdt_chan #(
  parameter W = 32
) (
  input  wire         sys_clk,
  input  wire         nrst,
  input  wire         enable,
  input  wire         tick,
  input  wire [W-1:0] start_value,
  input  wire         cnt_wr,
  input  wire [W-1:0] cnt_wdata,
  output reg  [W-1:0] live_count_value,
  output reg          underflow
);
  reg en_d_reg;
  wire start_now = enable & ~en_d_reg;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      live_count_value <= `DRDT_CNT_RST;
      underflow        <= 1'b0;
      en_d_reg         <= 1'b0;
    end else begin
      en_d_reg  <= enable;
      underflow <= 1'b0;
      if (cnt_wr) begin
        live_count_value <= cnt_wdata;
      end else if (start_now) begin
        live_count_value <= start_value;
      end else if (enable && tick) begin
        if (live_count_value == {W{1'b0}}) begin
          live_count_value <= start_value;
          underflow        <= 1'b1;
        end else begin
          live_count_value <= live_count_value - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // drdt_chan
`default_nettype wire

// >>> hw/drdt_top.v
`timescale 1ns/1ps
`default_nettype none
`include "drdt_map.vh"
module drdt_top #(
  parameter W = 32
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq
);
  reg [`DRDT_DIV_W-1:0] shared_prescale_divider_reg;
  reg [`DRDT_DIV_W-1:0] pre_cnt_reg;
  reg                   tick_reg;
  reg [1:0]             timer_enable_control_reg;
  reg [W-1:0]           start0_reg;
  reg [W-1:0]           start1_reg;
  reg [1:0]             irq_stat_reg;
  reg [1:0]             irq_en_reg;
  reg                   aw_ok_reg;
  reg                   w_ok_reg;
  reg [5:0]             awaddr_reg;
  reg [31:0]            wdata_reg;
  reg [3:0]             wstrb_reg;
  wire [W-1:0]          cnt0;
  wire [W-1:0]          cnt1;
  wire [1:0]            uflow;
  wire                  do_wr = aw_ok_reg & w_ok_reg & ~s_axi_bvalid;
  wire                  wr_c0 = do_wr && awaddr_reg == `DRDT_OFS_T0_COUNT;
  wire                  wr_c1 = do_wr && awaddr_reg == `DRDT_OFS_T1_COUNT;
  wire                  first_timer_enable  = timer_enable_control_reg[0];
  wire                  second_timer_enable = timer_enable_control_reg[1];
  reg  [31:0]           merged;

  always @* begin
    merged = 32'h00000000;
    if (awaddr_reg == `DRDT_OFS_T0_START) begin
      merged = start0_reg;
    end else if (awaddr_reg == `DRDT_OFS_T1_START) begin
      merged = start1_reg;
    end else if (awaddr_reg == `DRDT_OFS_T0_COUNT) begin
      merged = cnt0;
    end else if (awaddr_reg == `DRDT_OFS_T1_COUNT) begin
      merged = cnt1;
    end
    merged[7:0]   = wstrb_reg[0] ? wdata_reg[7:0]   : merged[7:0];
    merged[15:8]  = wstrb_reg[1] ? wdata_reg[15:8]  : merged[15:8];
    merged[23:16] = wstrb_reg[2] ? wdata_reg[23:16] : merged[23:16];
    merged[31:24] = wstrb_reg[3] ? wdata_reg[31:24] : merged[31:24];
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_reg <= `DRDT_DIV_RST;
      tick_reg    <= 1'b0;
    end else if (pre_cnt_reg >= shared_prescale_divider_reg) begin
      pre_cnt_reg <= `DRDT_DIV_RST;
      tick_reg    <= 1'b1;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
      tick_reg    <= 1'b0;
    end
  end

  // reload at zero gives start+1 ticks
  drdt_chan #(.W(W)) u_chan0 (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .enable           (first_timer_enable),
    .tick             (tick_reg),
    .start_value      (start0_reg),
    .cnt_wr           (wr_c0),
    .cnt_wdata        (merged[W-1:0]),
    .live_count_value (cnt0),
    .underflow        (uflow[0])
  );
  drdt_chan #(.W(W)) u_chan1 (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .enable           (second_timer_enable),
    .tick             (tick_reg),
    .start_value      (start1_reg),
    .cnt_wr           (wr_c1),
    .cnt_wdata        (merged[W-1:0]),
    .live_count_value (cnt1),
    .underflow        (uflow[1])
  );

  // Write channel: address and data accepted in either order
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready               <= 1'b1;
      s_axi_wready                <= 1'b1;
      s_axi_bvalid                <= 1'b0;
      s_axi_bresp                 <= `DRDT_RESP_OKAY;
      aw_ok_reg                   <= 1'b0;
      w_ok_reg                    <= 1'b0;
      awaddr_reg                  <= 6'h00;
      wdata_reg                   <= 32'h00000000;
      wstrb_reg                   <= 4'h0;
      shared_prescale_divider_reg <= `DRDT_DIV_RST;
      timer_enable_control_reg    <= `DRDT_EN_RST;
      start0_reg                  <= `DRDT_CNT_RST;
      start1_reg                  <= `DRDT_CNT_RST;
      irq_en_reg                  <= 2'h0;
      irq_stat_reg                <= 2'h0;
      irq                         <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= {s_axi_awaddr[5:2], 2'h0};
        aw_ok_reg     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_ok_reg     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      irq <= |(irq_stat_reg & irq_en_reg);
      if (do_wr) begin
        aw_ok_reg    <= 1'b0;
        w_ok_reg     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DRDT_RESP_OKAY;
        if (awaddr_reg == `DRDT_OFS_CONFIG) begin
          if (wstrb_reg[0]) shared_prescale_divider_reg <= wdata_reg[7:0];
        end else if (awaddr_reg == `DRDT_OFS_ENABLE) begin
          if (wstrb_reg[0]) timer_enable_control_reg <= wdata_reg[1:0];
        end else if (awaddr_reg == `DRDT_OFS_T0_START) begin
          start0_reg <= merged[W-1:0];
        end else if (awaddr_reg == `DRDT_OFS_T1_START) begin
          start1_reg <= merged[W-1:0];
        end else if (awaddr_reg == `DRDT_OFS_IRQ_EN) begin
          if (wstrb_reg[0]) irq_en_reg <= wdata_reg[1:0];
        end else if (awaddr_reg == `DRDT_OFS_IRQ_CLR) begin
          if (wstrb_reg[0]) irq_stat_reg <= (irq_stat_reg & ~wdata_reg[1:0]) | uflow;
        end else if (awaddr_reg != `DRDT_OFS_T0_COUNT &&
                     awaddr_reg != `DRDT_OFS_T1_COUNT &&
                     awaddr_reg != `DRDT_OFS_IRQ_STAT) begin
          s_axi_bresp <= `DRDT_RESP_SLVERR;
        end
      end
      if (!(do_wr && awaddr_reg == `DRDT_OFS_IRQ_CLR && wstrb_reg[0])) begin
        irq_stat_reg <= irq_stat_reg | uflow;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DRDT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `DRDT_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (s_axi_araddr[5:2] == `DRDT_OFS_CONFIG >> 2) begin
        s_axi_rdata[7:0] <= shared_prescale_divider_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_ENABLE >> 2) begin
        s_axi_rdata[1:0] <= timer_enable_control_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_T0_START >> 2) begin
        s_axi_rdata <= start0_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_T0_COUNT >> 2) begin
        s_axi_rdata <= cnt0;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_T1_START >> 2) begin
        s_axi_rdata <= start1_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_T1_COUNT >> 2) begin
        s_axi_rdata <= cnt1;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_IRQ_STAT >> 2) begin
        s_axi_rdata[1:0] <= irq_stat_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_IRQ_EN >> 2) begin
        s_axi_rdata[1:0] <= irq_en_reg;
      end else if (s_axi_araddr[5:2] == `DRDT_OFS_IRQ_CLR >> 2) begin
        s_axi_rdata <= 32'h00000000;
      end else begin
        s_axi_rresp <= `DRDT_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // drdt_top
`default_nettype wire

// >>> sim/drdt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module drdt_monitor (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
    else $error("read data dropped early");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AR_BUSY: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_AR_BACK: assert property (
    s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
    else $error("read channel not freed");
  AST_W_LAT: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  AST_AW_BUSY: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_W_BACK: assert property (
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("write channel not freed");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
endmodule // drdt_monitor
bind drdt_top drdt_monitor drdt_monitor_inst (.*);
`default_nettype wire

// >>> sim/drdt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drdt_top_tb;
  logic        sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, d2;
  logic [1:0]  bresp, rresp, r;
  integer      n_mismatch = 0, check_count = 0, cyc = 0, t1, c;

  drdt_top drdt_top_inst (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen %h expected %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task hang(input integer k, input integer lim);
    if (k >= lim) begin
      n_mismatch++;
      test_done;
    end
  endtask
  // Address and data offered together, each released once taken
  task wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] s);
    integer k;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    s = bresp;
    bready <= 1'b0;
    hang(k, 200);
  endtask
  task rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] s);
    integer k;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    s = rresp;
    rready <= 1'b0;
    hang(k, 200);
  endtask
  task w(input logic [5:0] a, input logic [31:0] v);
    wr(a, v, r);
    chk(r, 2'h0);
  endtask
  task wirq(output integer t);
    integer k;
    for (k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge sys_clk);
    t = cyc;
    hang(k, 2000);
  endtask

  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h00000000;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (c = 0; c < 36; c += 4) begin
      rd(c[5:0], d, r);
      chk(d, 32'h00000000);
    end
    rd(6'h24, d, r);
    chk(r, 2'h2);
    wr(6'h24, 32'h00000001, r);
    chk(r, 2'h2);
    $display("test reset_map done");
    // Divide by 4, reload 9: 40 clocks between underflows
    w(6'h00, 32'h00000003);
    w(6'h08, 32'h00000009);
    w(6'h1C, 32'h00000003);
    w(6'h04, 32'h00000001);
    wirq(t1);
    rd(6'h18, d, r);
    chk(d, 32'h00000001);
    w(6'h20, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    wirq(c);
    chk(c - t1, 40);
    $display("test period done");
    w(6'h04, 32'h00000000);
    w(6'h20, 32'h00000001);
    rd(6'h0C, d, r);
    repeat (60) @(posedge sys_clk);
    rd(6'h0C, d2, r);
    chk(d2, d);
    rd(6'h18, d, r);
    chk(d, 32'h00000000);
    w(6'h0C, 32'h00001234);
    rd(6'h0C, d, r);
    chk(d, 32'h00001234);
    $display("test hold_write done");
    w(6'h10, 32'h00000004);
    w(6'h04, 32'h00000002);
    wirq(t1);
    rd(6'h18, d, r);
    chk(d, 32'h00000002);
    w(6'h20, 32'h00000002);
    // Irq trails the status clear by a cycle; let it fall first
    repeat (2) @(posedge sys_clk);
    wirq(c);
    chk(c - t1, 20);
    w(6'h1C, 32'h00000001);
    w(6'h20, 32'h00000002);
    repeat (30) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(6'h18, d, r);
    chk(d, 32'h00000002);
    rd(6'h0C, d, r);
    chk(d, 32'h00001234);
    $display("test second_timer done");
    test_done;
  end
endmodule // drdt_top_tb
`default_nettype wire
